// [rtl/bsp_pkg.sv]
package bsp_pkg;
	localparam int BSP_LANE_BITS = 9;
	localparam int BSP_BURST_WORDS = 4;
	localparam int BSP_DATA_WIDTH_DEF = 18;
	localparam int BSP_ADDR_WIDTH_DEF = 8;
	localparam int BSP_SYNC_STAGES = 2;
	localparam logic [2:0] BSP_WORD0 = 3'h0;
	localparam logic [2:0] BSP_WORD1 = 3'h1;
	localparam logic [2:0] BSP_WORD2 = 3'h2;
	localparam logic [2:0] BSP_WORD3 = 3'h3;
	localparam logic [2:0] BSP_DONE = 3'h4;
	localparam logic BSP_OE_OFF = 1'b1;
endpackage : bsp_pkg

// [rtl/bsp_mem.sv]
`timescale 1ns/10ps
module bsp_mem
	import bsp_pkg::*;
#(
	parameter int ADDR_WIDTH = BSP_ADDR_WIDTH_DEF,
	parameter int LINE_WIDTH = BSP_DATA_WIDTH_DEF * BSP_BURST_WORDS
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [ADDR_WIDTH-1:0] wr_addr,
	input wire logic [LINE_WIDTH-1:0] wr_data,
	input wire logic [LINE_WIDTH/BSP_LANE_BITS-1:0] wr_lane_en,
	input wire logic rd_en,
	input wire logic [ADDR_WIDTH-1:0] rd_addr,
	output logic [LINE_WIDTH-1:0] rd_data
);
	localparam int LANES = LINE_WIDTH / BSP_LANE_BITS;
	logic [LINE_WIDTH-1:0] array [0:(1<<ADDR_WIDTH)-1];

	// Masked lanes keep their stored bits
	always_ff @(posedge clock) begin
		if (wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (wr_lane_en[i]) begin
					array[wr_addr][i*BSP_LANE_BITS +: BSP_LANE_BITS] <=
						wr_data[i*BSP_LANE_BITS +: BSP_LANE_BITS];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= array[rd_addr];
		end
	end
endmodule : bsp_mem

// [rtl/bsp_sram.sv]
// Operation
// RULE1: Write starts on low write select at K rise; words at K,K# of next two cycles.
// RULE2: Read starts on low read select at K rise; words out two and three cycles later.
// RULE3: Select that started an operation last rise is don't-care for the other port.
// RULE4: Controller never starts same port on consecutive K rises.
// RULE5: Second same-type request on the immediately following K rise is ignored.
// RULE6: Out of reset both ports idle and read outputs released.
// RULE7: Burst words map to address and next three locations, one word per edge; code keeps all four words in one array line per address.
// RULE8: Write data taken and read data launched on rises of both clocks.
// RULE9: Stopped clocks should rest high; device holds its state meanwhile.
// RULE10: Byte selects sampled with every write word, may differ per word.
// RULE11: Narrow width: select 0 writes bits 8:0, select 1 bits 17:9.
// RULE12: Narrow width: both selects high writes nothing for that word.
// RULE13: Wide width: selects 0..3 write bits 8:0, 17:9, 26:18, 35:27.
// RULE14: Wide width: all selects high writes nothing for that word.
// RULE15: Deselected read port finishes, then releases outputs after next K rise.
// RULE16: Both selected from idle: read wins, then ports alternate.
// RULE17: Read after write on previous rise returns the new write data.
// RULE18: Whole write burst committed to the array in one masked update.
`timescale 1ns/10ps
module bsp_sram
	import bsp_pkg::*;
#(
	parameter int DATA_WIDTH = BSP_DATA_WIDTH_DEF,
	parameter int ADDR_WIDTH = BSP_ADDR_WIDTH_DEF
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic k,
	input wire logic k_n,
	input wire logic read_port_sel_n,
	input wire logic write_port_sel_n,
	input wire logic [ADDR_WIDTH-1:0] addr,
	input wire logic [DATA_WIDTH-1:0] wr_data,
	input wire logic [DATA_WIDTH/BSP_LANE_BITS-1:0] byte_lane_wr_en_n,
	output logic [DATA_WIDTH-1:0] rd_data,
	output logic rd_data_oe_n
);
	localparam int LANES = DATA_WIDTH / BSP_LANE_BITS;
	localparam int LINE = DATA_WIDTH * BSP_BURST_WORDS;
	localparam int SW = 4 + ADDR_WIDTH + DATA_WIDTH + LANES;

	// All pins cross through the same two stages so they stay aligned with the clocks
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			// Clocks and selects rest high, so no false edge follows reset
			sync1 <= {{(SW-4){1'b0}}, 4'hf};
			sync2 <= {{(SW-4){1'b0}}, 4'hf};
		end else begin
			sync1 <= {byte_lane_wr_en_n, wr_data, addr, k, k_n, read_port_sel_n,
				write_port_sel_n};
			sync2 <= sync1;
		end
	end

	logic k_s;
	logic kn_s;
	logic rsel_s;
	logic wsel_s;
	logic [ADDR_WIDTH-1:0] addr_s;
	logic [DATA_WIDTH-1:0] d_s;
	logic [LANES-1:0] lane_s;
	assign {lane_s, d_s, addr_s, k_s, kn_s, rsel_s, wsel_s} = sync2;

	logic k_prev, kn_prev, rd_last, wr_last, rd_p1, rd_p2, w_armed, w_busy, fetch_d;
	logic [ADDR_WIDTH-1:0] ra1, ra2, wa_arm, wa_cur;
	logic [2:0] wcnt, ocnt;
	logic [LINE-1:0] wline, line;
	logic [LINE/BSP_LANE_BITS-1:0] wmask;
	logic next_rd_last, next_wr_last, next_rd_p1, next_rd_p2, next_w_armed, next_w_busy;
	logic next_fetch_d, next_rd_data_oe_n;
	logic [ADDR_WIDTH-1:0] next_ra1, next_ra2, next_wa_arm, next_wa_cur;
	logic [2:0] next_wcnt, next_ocnt;
	logic [LINE-1:0] next_wline, next_line;
	logic [LINE/BSP_LANE_BITS-1:0] next_wmask;
	logic [DATA_WIDTH-1:0] next_rd_data;
	logic k_rise, kn_rise, rd_acc, wr_acc, fetch, commit;
	logic [LINE-1:0] mem_rdata;

	always_comb begin
		k_rise = k_s & ~k_prev; // RULE8
		kn_rise = kn_s & ~kn_prev; // RULE8
		// A port started last rise has its select ignored
		rd_acc = k_rise & ~rsel_s & ~rd_last; // RULE2 RULE3 RULE5
		wr_acc = k_rise & ~wsel_s & ~wr_last & ~rd_acc; // RULE1 RULE3 RULE5 RULE16
		fetch = k_rise & rd_p2; // RULE2
		commit = 1'b0;
		next_rd_last = rd_last;
		next_wr_last = wr_last;
		next_rd_p1 = rd_p1;
		next_rd_p2 = rd_p2;
		next_ra1 = ra1;
		next_ra2 = ra2;
		next_w_armed = w_armed;
		next_wa_arm = wa_arm;
		next_w_busy = w_busy;
		next_wa_cur = wa_cur;
		next_wcnt = wcnt;
		next_wline = wline;
		next_wmask = wmask;
		next_fetch_d = fetch;
		next_line = line;
		next_ocnt = ocnt;
		next_rd_data = rd_data;
		next_rd_data_oe_n = rd_data_oe_n;
		if (k_rise) begin
			next_rd_last = rd_acc; // RULE16
			next_wr_last = wr_acc; // RULE16
			next_rd_p1 = rd_acc;
			next_rd_p2 = rd_p1;
			next_ra2 = ra1;
			if (rd_acc) begin
				next_ra1 = addr_s; // RULE2
			end
			if (w_busy && wcnt == BSP_WORD2) begin
				next_wline[DATA_WIDTH*2 +: DATA_WIDTH] = d_s; // RULE1 RULE7
				next_wmask[LANES*2 +: LANES] = ~lane_s; // RULE10 RULE11 RULE13
				next_wcnt = BSP_WORD3;
			end else if (w_armed) begin
				next_w_busy = 1'b1;
				next_wa_cur = wa_arm;
				next_wline[0 +: DATA_WIDTH] = d_s; // RULE1 RULE7
				next_wmask[0 +: LANES] = ~lane_s; // RULE10 RULE11 RULE13
				next_wcnt = BSP_WORD1;
			end
			next_w_armed = wr_acc;
			if (wr_acc) begin
				next_wa_arm = addr_s; // RULE1
			end
			if (ocnt == BSP_WORD2) begin
				next_rd_data = line[DATA_WIDTH*2 +: DATA_WIDTH]; // RULE7
				next_ocnt = BSP_WORD3;
			end else if (ocnt == BSP_DONE) begin
				next_ocnt = BSP_WORD0;
				// Stay driven when a new burst is already being fetched
				if (!fetch) begin
					next_rd_data_oe_n = BSP_OE_OFF; // RULE15
				end
			end
		end
		if (kn_rise && w_busy) begin
			if (wcnt == BSP_WORD1) begin
				next_wline[DATA_WIDTH +: DATA_WIDTH] = d_s; // RULE8
				next_wmask[LANES +: LANES] = ~lane_s; // RULE10
				next_wcnt = BSP_WORD2;
			end else if (wcnt == BSP_WORD3) begin
				next_wline[DATA_WIDTH*3 +: DATA_WIDTH] = d_s; // RULE8
				next_wmask[LANES*3 +: LANES] = ~lane_s; // RULE10
				next_wcnt = BSP_WORD0;
				next_w_busy = 1'b0;
				commit = 1'b1; // RULE18
			end
		end
		if (kn_rise) begin
			if (ocnt == BSP_WORD1) begin
				next_rd_data = line[DATA_WIDTH +: DATA_WIDTH]; // RULE8
				next_ocnt = BSP_WORD2;
			end else if (ocnt == BSP_WORD3) begin
				next_rd_data = line[DATA_WIDTH*3 +: DATA_WIDTH]; // RULE8
				next_ocnt = BSP_DONE;
			end
		end
		if (fetch_d) begin
			next_line = mem_rdata;
			next_rd_data = mem_rdata[0 +: DATA_WIDTH]; // RULE2 RULE7
			next_rd_data_oe_n = 1'b0;
			next_ocnt = BSP_WORD1;
		end
	end

	// Commit lands half a K period before a following read fetches, so the read sees it
	bsp_mem #(
		.ADDR_WIDTH(ADDR_WIDTH),
		.LINE_WIDTH(LINE)
	) u_mem (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(commit & (|next_wmask)), // RULE12 RULE14 RULE17
		.wr_addr(wa_cur),
		.wr_data(next_wline),
		.wr_lane_en(next_wmask), // RULE11 RULE13
		.rd_en(fetch),
		.rd_addr(ra2),
		.rd_data(mem_rdata)
	);

	// Without clock edges nothing advances, so state is simply held
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			k_prev <= 1'b1;
			kn_prev <= 1'b1;
			rd_last <= 1'b0;
			wr_last <= 1'b0;
			rd_p1 <= 1'b0; // RULE6
			rd_p2 <= 1'b0;
			ra1 <= '0;
			ra2 <= '0;
			w_armed <= 1'b0; // RULE6
			wa_arm <= '0;
			w_busy <= 1'b0;
			wa_cur <= '0;
			wcnt <= BSP_WORD0;
			wline <= '0;
			wmask <= '0;
			fetch_d <= 1'b0;
			line <= '0;
			ocnt <= BSP_WORD0;
			rd_data <= '0;
			rd_data_oe_n <= BSP_OE_OFF; // RULE6
		end else begin
			k_prev <= k_s;
			kn_prev <= kn_s;
			rd_last <= next_rd_last;
			wr_last <= next_wr_last;
			rd_p1 <= next_rd_p1;
			rd_p2 <= next_rd_p2;
			ra1 <= next_ra1;
			ra2 <= next_ra2;
			w_armed <= next_w_armed;
			wa_arm <= next_wa_arm;
			w_busy <= next_w_busy;
			wa_cur <= next_wa_cur;
			wcnt <= next_wcnt;
			wline <= next_wline;
			wmask <= next_wmask;
			fetch_d <= next_fetch_d;
			line <= next_line;
			ocnt <= next_ocnt;
			rd_data <= next_rd_data;
			rd_data_oe_n <= next_rd_data_oe_n;
		end
	end
endmodule : bsp_sram

// [sim/bsp_sram_sva.sv]
`timescale 1ns/10ps
module bsp_sram_sva
	import bsp_pkg::*;
#(
	parameter int DATA_WIDTH = BSP_DATA_WIDTH_DEF,
	parameter int ADDR_WIDTH = BSP_ADDR_WIDTH_DEF
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic k,
	input wire logic k_n,
	input wire logic read_port_sel_n,
	input wire logic write_port_sel_n,
	input wire logic [ADDR_WIDTH-1:0] addr,
	input wire logic [DATA_WIDTH-1:0] wr_data,
	input wire logic [DATA_WIDTH/BSP_LANE_BITS-1:0] byte_lane_wr_en_n,
	input wire logic [DATA_WIDTH-1:0] rd_data,
	input wire logic rd_data_oe_n
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	sequence s_start;
		$fell(rd_data_oe_n);
	endsequence
	sequence s_held;
		(!rd_data_oe_n) [*8];
	endsequence
	a_quiet_reset: assert property ($rose(reset_n) |-> (rd_data_oe_n && rd_data == '0) [*8])
		else $error("early read");
	a_read_latency: assert property (s_start |-> !$past(read_port_sel_n, 29))
		else $error("read late");
	a_burst_hold: assert property (s_start |=> s_held)
		else $error("burst short");
	a_port_release: assert property ($rose(rd_data_oe_n) |-> $past(read_port_sel_n, 29))
		else $error("bad release");
	a_word_spacing: assert property ($changed(rd_data) |=> $stable(rd_data) [*4])
		else $error("word short");
	a_drive_only: assert property ($changed(rd_data) |-> !rd_data_oe_n)
		else $error("undriven word");
	a_start_on_k: assert property (s_start |-> $past(k, 3) && !$past(k, 7))
		else $error("start off K");
	a_word_on_edge: assert property ($changed(rd_data) |-> $past(k, 3) != $past(k, 7))
		else $error("word off edge");
endmodule : bsp_sram_sva
bind bsp_sram bsp_sram_sva #(.DATA_WIDTH(DATA_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) u_sva (
	.clock(clock), .reset_n(reset_n), .k(k), .k_n(k_n), .read_port_sel_n(read_port_sel_n),
	.write_port_sel_n(write_port_sel_n), .addr(addr), .wr_data(wr_data),
	.byte_lane_wr_en_n(byte_lane_wr_en_n), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n));

// [sim/bsp_ctrl_model.sv]
`timescale 1ns/10ps
module bsp_ctrl_model
	import bsp_pkg::*;
(
	output logic k,
	output logic k_n,
	output logic rsel_n,
	output logic wsel_n,
	output logic [BSP_ADDR_WIDTH_DEF-1:0] addr,
	output logic [BSP_DATA_WIDTH_DEF-1:0] wr_data,
	output logic [BSP_DATA_WIDTH_DEF/BSP_LANE_BITS-1:0] lane_n,
	input wire logic [BSP_DATA_WIDTH_DEF-1:0] rd_data,
	input wire logic rd_data_oe_n
);
	logic [BSP_DATA_WIDTH_DEF:0] cap [$];
	initial begin
		{k, k_n, rsel_n, wsel_n} = 4'hf;
		addr = 8'h00;
		wr_data = '0;
		lane_n = '1;
	end
	// One K period; read port sampled just before each rise
	task automatic cyc(input logic rs, ws, input logic [7:0] a, input logic [17:0] d0, d1,
		input logic [1:0] l0, l1);
		rsel_n = rs;
		wsel_n = ws;
		addr = a;
		wr_data = d0;
		lane_n = l0;
		k = 1'b0;
		#31.25;
		// A released bus shows the inverse, so reading it late cannot pass
		cap.push_back({rd_data_oe_n, rd_data_oe_n ? ~rd_data : rd_data});
		{k, k_n} = 2'b10;
		#31.25;
		{rsel_n, wsel_n} = 2'b11;
		addr = ~a; // Never leave a stale address
		wr_data = d1;
		lane_n = l1;
		#31.25;
		cap.push_back({rd_data_oe_n, rd_data_oe_n ? ~rd_data : rd_data});
		{k, k_n} = 2'b01;
		#31.25;
	endtask : cyc
	task automatic stop();
		k = 1'b1;
		wr_data = ~wr_data;
		// Both clocks rest high for a while before the next cycle
		#250;
	endtask : stop
endmodule : bsp_ctrl_model

// [sim/tb.sv]
`timescale 1ns/10ps
module tb;
	import bsp_pkg::*;
	localparam int DW = BSP_DATA_WIDTH_DEF;
	localparam logic [DW-1:0] W [4] = '{18'h1_1111, 18'h2_2222, 18'h3_3333, 18'h0_4444};
	logic clock, reset_n, k, k_n, rsel_n, wsel_n, rd_data_oe_n;
	logic [7:0] addr;
	logic [DW-1:0] wr_data, rd_data;
	logic [1:0] lane_n;
	logic [DW-1:0] m5 [4];
	logic [DW-1:0] m6 [4];
	int err_count, total_checks;
	bsp_sram u_bsp_sram (.clock(clock), .reset_n(reset_n), .k(k), .k_n(k_n),
		.read_port_sel_n(rsel_n), .write_port_sel_n(wsel_n), .addr(addr), .wr_data(wr_data),
		.byte_lane_wr_en_n(lane_n), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n));
	bsp_ctrl_model ctrl (.k(k), .k_n(k_n), .rsel_n(rsel_n), .wsel_n(wsel_n), .addr(addr),
		.wr_data(wr_data), .lane_n(lane_n), .rd_data(rd_data), .rd_data_oe_n(rd_data_oe_n));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic cmp(input logic [DW:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR read word expected %h seen %h", e, g);
		end
	endtask : cmp
	task automatic idle(input int n);
		repeat (n) ctrl.cyc(1'b1, 1'b1, 8'h00, '0, '0, '1, '1);
		ctrl.stop();
	endtask : idle
	// Burst of a read taken at cycle r; rel also expects the port let go
	task automatic burst(input int r, input logic [DW-1:0] m [4], input bit rel);
		for (int i = 0; i < 4; i++) cmp({1'b0, m[i]}, ctrl.cap[2 * r + 5 + i]);
		if (rel) cmp({1'b1, ~m[3]}, ctrl.cap[2 * r + 9]);
		ctrl.cap.delete();
	endtask : burst
	task automatic t_fwd();
		ctrl.cyc(1'b1, 1'b0, 8'h05, '0, '0, '1, '1);
		ctrl.cyc(1'b0, 1'b1, 8'h05, W[0], W[1], '0, '0);
		ctrl.cyc(1'b1, 1'b1, 8'h00, W[2], W[3], '0, '0);
		idle(3);
		m5 = W;
		burst(1, m5, 1'b1);
	endtask : t_fwd
	task automatic t_mask();
		logic [1:0] l [4] = '{2'b10, 2'b01, 2'b11, 2'b00};
		logic [DW-1:0] mk;
		ctrl.cyc(1'b1, 1'b0, 8'h05, '0, '0, '1, '1);
		ctrl.cyc(1'b1, 1'b1, 8'h00, '0, '0, l[0], l[1]);
		ctrl.cyc(1'b0, 1'b1, 8'h05, '0, 18'h3_ffff, l[2], l[3]);
		idle(4);
		for (int i = 0; i < 4; i++) begin
			mk = {{9{!l[i][1]}}, {9{!l[i][0]}}};
			m5[i] = (m5[i] & ~mk) | ((i == 3) ? mk : '0);
		end
		burst(2, m5, 1'b1);
	endtask : t_mask
	task automatic t_refuse();
		ctrl.cyc(1'b0, 1'b1, 8'h05, '0, '0, '1, '1);
		ctrl.cyc(1'b0, 1'b1, 8'h06, '0, '0, '1, '1);
		idle(3);
		burst(0, m5, 1'b1);
	endtask : t_refuse
	task automatic t_prio();
		m6 = '{W[3], W[2], W[1], W[0]};
		ctrl.cyc(1'b0, 1'b0, 8'h05, '0, '0, '1, '1);
		ctrl.cyc(1'b0, 1'b0, 8'h06, '0, '0, '1, '1);
		ctrl.cyc(1'b0, 1'b0, 8'h05, m6[0], m6[1], '0, '0);
		ctrl.cyc(1'b1, 1'b1, 8'h00, m6[2], m6[3], '0, '0);
		ctrl.cyc(1'b0, 1'b1, 8'h06, '0, '0, '1, '1);
		idle(4);
		for (int i = 0; i < 8; i++) cmp({1'b0, m5[i % 4]}, ctrl.cap[5 + i]);
		burst(4, m6, 1'b1);
	endtask : t_prio
	task automatic tally_and_finish();
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		err_count = 0;
		total_checks = 0;
		reset_n = 1'b0;
		repeat (4) @(posedge clock);
		#1 reset_n = 1'b1;
		repeat (5) @(posedge clock);
		t_fwd();
		t_mask();
		t_refuse();
		t_prio();
		tally_and_finish();
	end
	initial begin
		#50000;
		err_count++;
		tally_and_finish();
	end
endmodule : tb
